// [rtl/otg_status_pkg.sv]
// package: register map, field positions, reset values and timing for the otg status block
package otg_status_pkg;
    // register byte addresses on the plain register port
    localparam logic [7:0] OTG_STATUS_ADDR = 8'h00;
    localparam logic [7:0] DEVICE_OPTIONS_ADDR = 8'h04;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h08;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
    localparam logic [7:0] LINE_CONTROL_ADDR = 8'h10;

    // status register field positions
    localparam int CABLE_TYPE_BIT = 7;
    localparam int LINE_STABLE_BIT = 5;
    localparam int SESSION_VALID_BIT = 3;
    localparam int B_SESSION_END_BIT = 2;
    localparam int A_VBUS_VALID_BIT = 0;
    localparam logic [31:0] OTG_STATUS_IMPL_MASK = 32'h0000_00ad;

    // device options field positions
    localparam int VBUS_OWNER_BIT = 15;
    localparam int CABLE_OWNER_BIT = 14;
    localparam int USER_CODE_LSB = 16;
    localparam int USER_CODE_MSB = 31;
    localparam logic [31:0] DEVICE_OPTIONS_RESET = 32'h0000_0000;
    localparam logic [31:0] DEVICE_OPTIONS_WMASK = 32'hffff_c000;
    localparam logic [31:0] DEVICE_OPTIONS_RSVD = 32'h0000_3fff;

    // line control field positions (usb control fragment)
    localparam int SE0_BIT = 6;
    localparam int J_LINE_BIT = 7;

    // reset values
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [7:0] IRQ_RESET = 8'h00;

    // line stability window
    localparam int CLOCK_HZ = 25_000_000;
    localparam int STABLE_TIME_US = 1000;
    localparam int STABLE_CYCLES = (CLOCK_HZ / 1_000_000) * STABLE_TIME_US;
endpackage

// [rtl/pin_sync.sv]
// module: two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,              // block clock
    input wire logic reset,                // synchronous, active high
    input wire logic [WIDTH-1:0] pinIn,    // asynchronous pins
    output logic [WIDTH-1:0] pinSync       // synchronised levels
);
    logic [WIDTH-1:0] stage1_reg; // first stage, read only by second

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync width must be at least one");
        end
    end

    // two flip-flops per pin
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1_reg <= '0;
            pinSync <= '0;
        end else begin
            stage1_reg <= pinIn;
            pinSync <= stage1_reg;
        end
    end
endmodule

// [rtl/otg_status_block.sv]
// module: otg status register, device option pin ownership and status interrupts
//
// What this block does
// - bit 7 high unless type a cable
// - bit 5 high when line held 1 ms
// - bit 3 shows session valid comparator
// - bit 2 shows b session end comparator
// - bit 0 shows a vbus valid comparator
// - unimplemented status bits read zero
// - option bit 15 gives usb vbus switch
// - option bit 14 gives usb cable pin
// - option bits 31-16 hold user code
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
module otg_status_block
    import otg_status_pkg::*;
#(
    parameter int STABLE_COUNT = STABLE_CYCLES
) (
    input wire logic ref_clk,                 // 25 mhz block clock
    input wire logic reset,                   // synchronous, active high
    input wire logic [7:0] regAddr,           // register byte address
    input wire logic [31:0] regWdata,         // write data
    input wire logic regWrite,                // write strobe
    input wire logic regRead,                 // read strobe
    output logic [31:0] regRdata,             // read data, cycle after strobe
    input wire logic cableSenseIn,            // cable sense pin level
    output logic cableSenseOut,               // cable sense pin drive value
    output logic cableSenseOe,                // cable sense pin drive enable
    input wire logic sessionValidIn,          // session valid comparator
    input wire logic bSessionEndIn,           // b session end comparator
    input wire logic aVbusValidIn,            // a vbus valid comparator
    input wire logic usbVbusOn,               // usb module vbus switch request
    input wire logic usbCableOut,             // usb module cable pin value
    input wire logic usbCableOe,              // usb module cable pin enable
    input wire logic portVbusOut,             // port logic vbus switch value
    input wire logic portVbusOe,              // port logic vbus switch enable
    input wire logic portCableOut,            // port logic cable pin value
    input wire logic portCableOe,             // port logic cable pin enable
    output logic portCableIn,                 // cable pin level back to port logic
    output logic vbusSwitchPin,               // vbus switch pin value
    output logic vbusSwitchOe,                // vbus switch pin enable
    output logic irq                          // level interrupt
);
    // counter width: must hold STABLE_COUNT itself
    localparam int CNT_W = $clog2(STABLE_COUNT + 1);

    // usage notes for whoever drives this block
    // - status bits 7, 3, 2 and 0 trail their pins by two clocks
    // - the two synchroniser flops read zero for two clocks after reset
    // - so the first live pin levels may raise change events
    // - the line stable bit needs STABLE_COUNT quiet clocks
    // - a line write that repeats the old value does not restart it
    // - the line counter restarts one clock after the write lands
    // - the status address is read only; writes there are dropped
    // - option bits 13 to 0 read back as ones and take no writes
    // - option bits 15 and 14 hand the two pins to the usb module
    // - with both option bits low the port logic owns both pins
    // - the usb module always drives the vbus switch it owns
    // - event flags set on both edges of every implemented status bit
    // - an event and a clear in one clock leave the flag set
    // - the interrupt is a level, high while a masked-in flag is set
    // - read data stand for one clock and are zero otherwise
    // - unmapped addresses read zero and ignore writes
    // - a pin owned by the usb module ignores port requests
    // - the port logic sees zero on the cable pin it does not own

    // elaboration checks on the parameter
    initial begin
        if (STABLE_COUNT < 1) begin
            $error("stable count must be at least one");
        end
        if (CNT_W > 31) begin
            $error("stable count too large for the window counter");
        end
    end

    // one register strobe aimed at one address
    function automatic logic strobe_hit(
        input logic strobe,          // write or read strobe
        input logic [7:0] addr,      // address on the port
        input logic [7:0] target     // register address
    );
        return strobe && (addr == target);
    endfunction

    // read value of the line control register
    function automatic logic [31:0] line_word(
        input logic [1:0] bits       // j condition and se0
    );
        logic [31:0] word;           // assembled word
        word = 32'h0000_0000;
        word[J_LINE_BIT] = bits[1];
        word[SE0_BIT] = bits[0];
        return word;
    endfunction

    // zero extend an 8-bit interrupt register
    function automatic logic [31:0] irq_word(
        input logic [7:0] bits       // status or mask bits
    );
        return {24'h000000, bits};
    endfunction

    logic [3:0] syncPins;                     // synchronised pin levels
    logic cableType;                          // 1: none or type b
    logic sessionValid;                       // synchronised session valid
    logic bSessionEnd;                        // synchronised b session end
    logic aVbusValid;                         // synchronised a vbus valid
    logic [31:0] options_reg;                 // device options word
    logic [1:0] lineCtrl_reg;                 // se0 and j condition bits
    logic [1:0] lineLast_reg;                 // previous line state
    logic [CNT_W-1:0] stableCnt_reg;          // cycles line unchanged
    logic lineStable;                         // stable for full window
    logic [31:0] status;                      // assembled status word
    logic [7:0] statusLast_reg;               // status for edge detect
    logic [7:0] irqStatus_reg;                // sticky change flags
    logic [7:0] irqMask_reg;                  // interrupt enables
    logic [7:0] irqEvents;                    // change events this cycle
    logic [7:0] irqClear;                     // write one to clear
    logic vbusOwner;                          // usb owns vbus switch
    logic cableOwner;                         // usb owns cable pin

    // write strobes, one per writable register
    logic optionsWr;                          // options word write
    logic lineWr;                             // line control write
    logic irqStatusWr;                        // interrupt status write
    logic irqMaskWr;                          // interrupt mask write

    // write decode shared by the register processes
    assign optionsWr = strobe_hit(regWrite, regAddr, DEVICE_OPTIONS_ADDR);
    assign lineWr = strobe_hit(regWrite, regAddr, LINE_CONTROL_ADDR);
    assign irqStatusWr = strobe_hit(regWrite, regAddr, IRQ_STATUS_ADDR);
    assign irqMaskWr = strobe_hit(regWrite, regAddr, IRQ_MASK_ADDR);

    // comparators and cable pin cross into ref_clk
    pin_sync #(
        .WIDTH(4)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .pinIn({cableSenseIn, sessionValidIn, bSessionEndIn, aVbusValidIn}),
        .pinSync(syncPins)
    );

    assign cableType = syncPins[3];
    assign sessionValid = syncPins[2];
    assign bSessionEnd = syncPins[1];
    assign aVbusValid = syncPins[0];

    // device options word, writable fields only
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            options_reg <= DEVICE_OPTIONS_RESET;
        end else if (optionsWr) begin
            // reserved bits never stored, they read as ones
            options_reg <= regWdata & DEVICE_OPTIONS_WMASK;
        end
    end

    // line state bits written by software
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lineCtrl_reg <= 2'h0;
        end else if (lineWr) begin
            // only j condition and se0 are kept
            lineCtrl_reg <= {regWdata[J_LINE_BIT], regWdata[SE0_BIT]};
        end
    end

    // count cycles the line state has held
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            lineLast_reg <= 2'h0;
            stableCnt_reg <= '0;
        end else begin
            lineLast_reg <= lineCtrl_reg;
            if (lineCtrl_reg != lineLast_reg) begin
                // either line bit moved: window starts again
                stableCnt_reg <= '0;
            end else if (stableCnt_reg != CNT_W'(STABLE_COUNT)) begin
                // saturate so a long quiet line stays stable
                stableCnt_reg <= stableCnt_reg + 1'b1;
            end
        end
    end

    assign lineStable = (stableCnt_reg == CNT_W'(STABLE_COUNT));

    // status word, unimplemented bits forced low
    always_comb begin
        status = STATUS_RESET;
        status[CABLE_TYPE_BIT] = cableType;
        status[LINE_STABLE_BIT] = lineStable;
        status[SESSION_VALID_BIT] = sessionValid;
        status[B_SESSION_END_BIT] = bSessionEnd;
        status[A_VBUS_VALID_BIT] = aVbusValid;
        status = status & OTG_STATUS_IMPL_MASK;
    end

    // change of any status bit is an event
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            statusLast_reg <= IRQ_RESET;
        end else begin
            statusLast_reg <= status[7:0];
        end
    end

    // events: any implemented status bit that moved
    always_comb begin
        irqEvents = status[7:0] ^ statusLast_reg;
        irqEvents = irqEvents & OTG_STATUS_IMPL_MASK[7:0];
    end

    // write one to clear, only on the status address
    always_comb begin
        if (irqStatusWr) begin
            irqClear = regWdata[7:0];         // ones clear flags
        end else begin
            irqClear = 8'h00;                 // nothing cleared
        end
    end

    // sticky flags, set wins over clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irqStatus_reg <= IRQ_RESET;
        end else begin
            irqStatus_reg <= (irqStatus_reg & ~irqClear) | irqEvents;
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            irqMask_reg <= IRQ_RESET;
        end else if (irqMaskWr) begin
            // unimplemented positions cannot be enabled
            irqMask_reg <= regWdata[7:0] & OTG_STATUS_IMPL_MASK[7:0];
        end
    end

    // level interrupt from registered flags
    assign irq = |(irqStatus_reg & irqMask_reg);

    // read mux, one clock of data after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            regRdata <= 32'h0000_0000;                // quiet port in reset
        end else if (regRead) begin
            unique case (regAddr)
                OTG_STATUS_ADDR: begin
                    regRdata <= status;
                end
                DEVICE_OPTIONS_ADDR: begin
                    regRdata <= options_reg | DEVICE_OPTIONS_RSVD;
                end
                IRQ_STATUS_ADDR: begin
                    regRdata <= irq_word(irqStatus_reg); // sticky flags
                end
                IRQ_MASK_ADDR: begin
                    regRdata <= irq_word(irqMask_reg);   // enables
                end
                LINE_CONTROL_ADDR: begin
                    regRdata <= line_word(lineCtrl_reg); // line stand-in
                end
                default: begin
                    regRdata <= 32'h0000_0000;           // unmapped reads zero
                end
            endcase
        end else begin
            regRdata <= 32'h0000_0000;                   // data stand one clock
        end
    end

    // pin ownership from option bits
    assign vbusOwner = options_reg[VBUS_OWNER_BIT];
    assign cableOwner = options_reg[CABLE_OWNER_BIT];

    // vbus switch pin: usb module or port logic
    always_comb begin
        if (vbusOwner) begin
            vbusSwitchPin = usbVbusOn;
            vbusSwitchOe = 1'b1;              // usb always drives its switch
        end else begin
            vbusSwitchPin = portVbusOut;
            vbusSwitchOe = portVbusOe;        // port decides direction
        end
    end

    // cable pin drive: usb module or port logic
    always_comb begin
        if (cableOwner) begin
            cableSenseOut = usbCableOut;
            cableSenseOe = usbCableOe;        // usb may leave it as input
        end else begin
            cableSenseOut = portCableOut;
            cableSenseOe = portCableOe;       // port decides direction
        end
    end

    // cable pin level back to the port logic only while it owns the pin
    always_comb begin
        if (cableOwner) begin
            portCableIn = 1'b0;
        end else begin
            portCableIn = cableType;          // synchronised level
        end
    end
endmodule

// [testbench/otg_status_block_assertions.sv]
// checker: port level assertions for the otg status block
`timescale 1ns/100ps
module otg_status_block_assertions
    import otg_status_pkg::*;
#(
    parameter int STABLE_COUNT = 8
) (
    input wire logic ref_clk, reset, regWrite, regRead, // clock, reset, strobes
    input wire logic [7:0] regAddr, // byte address
    input wire logic [31:0] regWdata, regRdata, // bus data
    input wire logic cableSenseIn, sessionValidIn, bSessionEndIn, aVbusValidIn, // levels
    input wire logic usbVbusOn, usbCableOut, usbCableOe, portVbusOut, portVbusOe, // requests
    input wire logic portCableOut, portCableOe, vbusSwitchPin, vbusSwitchOe, // cable requests, vbus pin
    input wire logic cableSenseOut, cableSenseOe // cable pin drive
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [31:0] optReg; // shadow of the option word
    logic [1:0] lineReg; // shadow of the line bits
    logic [15:0] quietCnt; // cycles since a line change
    logic [2:0] upCnt; // cycles since reset, saturating
    logic [3:0] pins; // sensed levels
    logic stRd, lineWr; // status read, line write
    assign pins = {cableSenseIn, sessionValidIn, bSessionEndIn, aVbusValidIn};
    assign stRd = regRead && regAddr == OTG_STATUS_ADDR;
    assign lineWr = regWrite && regAddr == LINE_CONTROL_ADDR;
    // shadows follow software writes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            optReg <= DEVICE_OPTIONS_RESET;
            lineReg <= 2'h0;
            quietCnt <= 16'h0;
            upCnt <= 3'h0;
        end else begin
            if (regWrite && regAddr == DEVICE_OPTIONS_ADDR)
                optReg <= regWdata & DEVICE_OPTIONS_WMASK;
            if (lineWr) lineReg <= regWdata[7:6];
            if (lineWr && regWdata[7:6] != lineReg) quietCnt <= 16'h0;
            else if (quietCnt != 16'hffff) quietCnt <= quietCnt + 16'h1;
            if (upCnt != 3'h7) upCnt <= upCnt + 3'h1;
        end
    end
    // levels settled long enough to reach the status word
    sequence settledRd;
        (upCnt == 3'h7 && $stable(pins))[*4] ##0 stRd;
    endsequence
    AST_VBUS_MUX: assert property (
        vbusSwitchPin == (optReg[VBUS_OWNER_BIT] ? usbVbusOn : portVbusOut)
        && vbusSwitchOe == (optReg[VBUS_OWNER_BIT] | portVbusOe)) else $error("vbus pin mux");
    AST_CABLE_MUX: assert property (
        cableSenseOut == (optReg[CABLE_OWNER_BIT] ? usbCableOut : portCableOut)
        && cableSenseOe == (optReg[CABLE_OWNER_BIT] ? usbCableOe : portCableOe))
        else $error("cable pin mux");
    AST_RDATA_IDLE: assert property (
        !$past(regRead) |-> regRdata == 32'h0) else $error("read data outside answer cycle");
    AST_STATUS_RSVD: assert property (
        stRd |=> (regRdata & ~OTG_STATUS_IMPL_MASK) == 32'h0) else $error("status reserved bit");
    AST_LEVELS: assert property (
        settledRd |=> regRdata[3:0] == {$past(pins[2:1]), 1'b0, $past(pins[0])})
        else $error("comparator bits");
    AST_CABLE_TYPE: assert property (
        settledRd |=> regRdata[CABLE_TYPE_BIT] == $past(pins[3])) else $error("cable type bit");
    AST_LINE_STABLE: assert property (
        stRd && (quietCnt < STABLE_COUNT || quietCnt > STABLE_COUNT + 4) |=>
        regRdata[LINE_STABLE_BIT] == ($past(quietCnt) > STABLE_COUNT)) else $error("line bit");
    AST_OPTIONS_READ: assert property (
        regRead && regAddr == DEVICE_OPTIONS_ADDR |=>
        regRdata == ($past(optReg) | DEVICE_OPTIONS_RSVD)) else $error("option word readback");
endmodule

bind otg_status_block otg_status_block_assertions #(.STABLE_COUNT(STABLE_COUNT)) chk (.*);

// [testbench/usb_peer.sv]
// partner: cable plug and vbus comparators facing the otg block
`timescale 1ns/100ps
module usb_peer #(
    parameter int SETTLE_NS = 3 // comparator settling delay
) (
    input wire logic typeA, // a type plug grounds the cable pin
    input wire logic [1:0] vbusLevel, // 0 none up to 3 above a valid
    input wire logic idOut, // block drive value
    input wire logic idOe, // block drive enable
    output logic idPin, // resolved cable pin
    output logic sessionValid, // session valid comparator
    output logic bSessionEnd, // b session end comparator
    output logic aVbusValid // a vbus valid comparator
);
    // pulled up unless driven or grounded by the plug
    assign idPin = idOe ? idOut : !typeA;
    // thresholds from lowest to highest
    assign #SETTLE_NS bSessionEnd = vbusLevel >= 2'h1;
    assign #SETTLE_NS sessionValid = vbusLevel >= 2'h2;
    assign #SETTLE_NS aVbusValid = vbusLevel == 2'h3;
endmodule

// [testbench/testbench.sv]
// testbench: otg status block against the cable and vbus peer
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module testbench;
    import otg_status_pkg::*;
    localparam int STABLE = 8; // short line window
    logic ref_clk = 1'b0, reset = 1'b1, regWrite = 1'b0, regRead = 1'b0, typeA = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [1:0] vbusLevel = 2'h0;
    logic [6:0] drv = 7'h00; // usb and port pin requests
    logic cIn, cOut, cOe, sv, bse, avv, portIn, vPin, vOe, irq;
    int n_errors = 0, n_checks = 0;
    typedef struct {logic a; logic [1:0] lvl; logic [31:0] exp;} row_type;
    row_type rows [5] = '{'{1'h0, 2'h0, 32'ha0}, '{1'h1, 2'h0, 32'h20}, '{1'h0, 2'h1, 32'ha4},
        '{1'h0, 2'h2, 32'hac}, '{1'h1, 2'h3, 32'h2d}};
    otg_status_block #(.STABLE_COUNT(STABLE)) dut (.ref_clk(ref_clk), .reset(reset),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .cableSenseIn(cIn), .cableSenseOut(cOut), .cableSenseOe(cOe),
        .sessionValidIn(sv), .bSessionEndIn(bse), .aVbusValidIn(avv), .usbVbusOn(drv[6]),
        .usbCableOut(drv[5]), .usbCableOe(drv[4]), .portVbusOut(drv[3]), .portVbusOe(drv[2]),
        .portCableOut(drv[1]), .portCableOe(drv[0]), .portCableIn(portIn),
        .vbusSwitchPin(vPin), .vbusSwitchOe(vOe), .irq(irq));
    usb_peer peer (.typeA(typeA), .vbusLevel(vbusLevel), .idOut(cOut), .idOe(cOe),
        .idPin(cIn), .sessionValid(sv), .bSessionEnd(bse), .aVbusValid(avv));
    // one write cycle
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask
    // one read cycle, data compared in the answer cycle
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge ref_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial forever #20 ref_clk = ~ref_clk;
    // watchdog well beyond the expected run
    initial begin
        repeat (2000) @(posedge ref_clk);
        n_errors++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge ref_clk);
        reset <= 1'b0;
        rd(DEVICE_OPTIONS_ADDR, DEVICE_OPTIONS_RESET | DEVICE_OPTIONS_RSVD);
        foreach (rows[i]) begin
            typeA <= rows[i].a;
            vbusLevel <= rows[i].lvl;
            repeat (STABLE + 6) @(posedge ref_clk);
            rd(OTG_STATUS_ADDR, rows[i].exp);
            `CHK(portIn, !rows[i].a)
        end
        wr(OTG_STATUS_ADDR, 32'hffffffff);
        rd(OTG_STATUS_ADDR, 32'h2d);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'h0);
        $display("done: levels");
        drv <= 7'h61;
        wr(DEVICE_OPTIONS_ADDR, 32'habcd_c000);
        rd(DEVICE_OPTIONS_ADDR, 32'habcd_ffff);
        `CHK({vPin, vOe, cOut, cOe}, 4'he)
        wr(DEVICE_OPTIONS_ADDR, 32'h1234_0000);
        rd(DEVICE_OPTIONS_ADDR, 32'h1234_3fff);
        `CHK({vPin, vOe, cOut, cOe}, 4'h1)
        drv <= 7'h00;
        $display("done: pins");
        wr(LINE_CONTROL_ADDR, 32'h80);
        repeat (2) @(posedge ref_clk);
        rd(OTG_STATUS_ADDR, 32'h0d);
        repeat (STABLE + 4) @(posedge ref_clk);
        rd(OTG_STATUS_ADDR, 32'h2d);
        wr(LINE_CONTROL_ADDR, 32'h80);
        rd(OTG_STATUS_ADDR, 32'h2d);
        $display("done: line");
        wr(IRQ_STATUS_ADDR, 32'hff);
        wr(IRQ_MASK_ADDR, 32'h84);
        rd(IRQ_STATUS_ADDR, 32'h0);
        vbusLevel <= 2'h0;
        repeat (6) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        wr(IRQ_MASK_ADDR, 32'h80);
        rd(IRQ_STATUS_ADDR, 32'h0d);
        `CHK(irq, 1'b0)
        wr(IRQ_MASK_ADDR, 32'h04);
        wr(IRQ_STATUS_ADDR, 32'h04);
        rd(IRQ_STATUS_ADDR, 32'h09);
        `CHK(irq, 1'b0)
        $display("done: interrupt");
        final_report();
    end
endmodule
